// ### rtl/pcueer_regs.sv
`timescale 1ns/1ns

module pcueer_regs
    import pcueer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        fundamentalReset,
    input  wire logic        global_reset_input,
    input  wire logic        powerOnReset,
    input  wire logic        virtual_channel_capability_enable,
    input  wire logic        cfgRead,
    input  wire logic        cfgWrite,
    input  wire logic [11:0] cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWriteData,
    input  wire logic        unsupported_request_flag,
    input  wire logic        end_to_end_crc_flag,
    input  wire logic        malformed_packet_flag,
    input  wire logic        receiveCreditOverrunFlag,
    input  wire logic        unmatched_completion_flag,
    input  wire logic        completer_abort_flag,
    input  wire logic        completion_timer_expired_flag,
    input  wire logic        flow_credit_protocol_flag,
    input  wire logic        poisoned_packet_flag,
    input  wire logic        linkLayerProtocolFlag,
    output logic      [31:0] cfgReadData,
    output logic             cfgReadValid,
    output logic             errMsgReq,
    output logic             errMsgFatal,
    output logic      [4:0]  firstErrorPointer,
    output logic             headerLogLoad
);

    // ==========================================================
    // helpers
    function automatic logic [31:0] pcueer_lane_mask(input logic [3:0] be);
        pcueer_lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : pcueer_lane_mask

    // lowest set bit wins when several classes arrive together
    function automatic logic [4:0] pcueer_first_pos(input logic [31:0] v);
        pcueer_first_pos = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                pcueer_first_pos = 5'(i);
            end
        end
    endfunction : pcueer_first_pos

    // lane-masked update; reserved bits can never be written to one
    function automatic logic [31:0] pcueer_merge(input logic [31:0] old,
                                                 input logic [31:0] wdata,
                                                 input logic [31:0] lanes);
        pcueer_merge = (old & ~lanes) | (wdata & lanes & PCUEER_IMPL_MASK);
    endfunction : pcueer_merge

    // ==========================================================
    // address decode
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_VERSION,
        SEL_STATUS,
        SEL_MASK,
        SEL_SEVERITY
    } pcueer_sel_type;

    // exact offset match only; neighbouring capability words live elsewhere
    function automatic pcueer_sel_type pcueer_decode(input logic [11:0] addr);
        if (addr == PCUEER_OFS_NEXT_CAP_VERSION) begin
            pcueer_decode = SEL_VERSION;
        end else if (addr == PCUEER_OFS_STATUS) begin
            pcueer_decode = SEL_STATUS;
        end else if (addr == PCUEER_OFS_MASK) begin
            pcueer_decode = SEL_MASK;
        end else if (addr == PCUEER_OFS_SEVERITY) begin
            pcueer_decode = SEL_SEVERITY;
        end else begin
            pcueer_decode = SEL_NONE;
        end
    endfunction : pcueer_decode

    // ==========================================================
    // state
    logic [31:0] errStatus;
    logic [31:0] errMask;
    logic [31:0] errSeverity;
    logic        fepValid;
    logic [31:0] next_errStatus;
    logic [31:0] next_errMask;
    logic [31:0] next_errSeverity;
    logic        next_fepValid;
    logic [4:0]  next_firstErrorPointer;
    logic [31:0] next_cfgReadData;
    logic        next_cfgReadValid;
    logic        next_errMsgReq;
    logic        next_errMsgFatal;
    logic        next_headerLogLoad;
    logic [31:0] rawEvents;
    logic [31:0] liveEvents;
    logic [31:0] laneMask;
    logic        anyReset;
    pcueer_sel_type regSel;

    assign anyReset = fundamentalReset | global_reset_input | powerOnReset;
    assign laneMask = pcueer_lane_mask(cfgByteEn);
    assign regSel   = pcueer_decode(cfgAddr);

    always_comb begin
        rawEvents = 32'h0000_0000;
        rawEvents[PCUEER_BIT_UR]   = unsupported_request_flag;
        rawEvents[PCUEER_BIT_ECRC] = end_to_end_crc_flag;
        rawEvents[PCUEER_BIT_MALF] = malformed_packet_flag;
        rawEvents[PCUEER_BIT_OVRN] = receiveCreditOverrunFlag;
        rawEvents[PCUEER_BIT_UNXP] = unmatched_completion_flag;
        rawEvents[PCUEER_BIT_CABT] = completer_abort_flag;
        rawEvents[PCUEER_BIT_CTMO] = completion_timer_expired_flag;
        rawEvents[PCUEER_BIT_FCPE] = flow_credit_protocol_flag;
        rawEvents[PCUEER_BIT_PSN]  = poisoned_packet_flag;
        rawEvents[PCUEER_BIT_DLLP] = linkLayerProtocolFlag;
        liveEvents = rawEvents & ~errMask & PCUEER_IMPL_MASK;
    end

    // ==========================================================
    // register writes and error capture
    always_comb begin
        next_errStatus   = errStatus;
        next_errMask     = errMask;
        next_errSeverity = errSeverity;
        if (cfgWrite) begin
            case (regSel)
                SEL_STATUS: begin
                    next_errStatus = errStatus & ~(cfgWriteData & laneMask);
                end
                SEL_MASK: begin
                    next_errMask = pcueer_merge(errMask, cfgWriteData, laneMask);
                end
                SEL_SEVERITY: begin
                    next_errSeverity = pcueer_merge(errSeverity, cfgWriteData, laneMask)
                                     | PCUEER_SEV_RO_ONE;
                end
                default: begin
                end
            endcase
        end
        next_errStatus = (next_errStatus | liveEvents) & PCUEER_IMPL_MASK;
    end

    // ==========================================================
    // first error pointer and message request
    always_comb begin
        next_fepValid          = fepValid;
        next_firstErrorPointer = firstErrorPointer;
        next_errMsgReq         = 1'b0;
        next_errMsgFatal       = errMsgFatal;
        next_headerLogLoad     = 1'b0;
        if (liveEvents != 32'h0000_0000) begin
            next_errMsgReq     = 1'b1;
            next_headerLogLoad = 1'b1;
            // fatal if any live error is fatal
            next_errMsgFatal   = |(liveEvents & errSeverity);
            if (!fepValid) begin
                next_fepValid          = 1'b1;
                next_firstErrorPointer = pcueer_first_pos(liveEvents);
            end
        end
        if (fepValid && !next_errStatus[firstErrorPointer]) begin
            next_fepValid = 1'b0;
        end
    end

    // ==========================================================
    // read path
    always_comb begin
        next_cfgReadValid = cfgRead;
        next_cfgReadData  = 32'h0000_0000;
        if (cfgRead) begin
            case (regSel)
                SEL_VERSION: begin
                    next_cfgReadData = {16'h0000,
                        (virtual_channel_capability_enable ? PCUEER_NEXT_PTR_VC
                                                           : PCUEER_NEXT_PTR_END),
                        PCUEER_CAP_REV};
                end
                SEL_STATUS: begin
                    next_cfgReadData = errStatus & PCUEER_IMPL_MASK;
                end
                SEL_MASK: begin
                    next_cfgReadData = errMask & PCUEER_IMPL_MASK;
                end
                SEL_SEVERITY: begin
                    next_cfgReadData = errSeverity | PCUEER_SEV_RO_ONE;
                end
                // unmapped offsets read zero
                default: begin
                    next_cfgReadData = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================================
    // registers: settings and status
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            errStatus   <= PCUEER_STATUS_RST;
            errMask     <= PCUEER_MASK_RST;
            errSeverity <= PCUEER_SEVERITY_RST;
        end else if (anyReset) begin
            errStatus   <= PCUEER_STATUS_RST;
            errMask     <= PCUEER_MASK_RST;
            errSeverity <= PCUEER_SEVERITY_RST;
        end else begin
            errStatus   <= next_errStatus;
            errMask     <= next_errMask;
            errSeverity <= next_errSeverity;
        end
    end

    // ==========================================================
    // registers: pointer and message request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fepValid          <= 1'b0;
            firstErrorPointer <= PCUEER_FEP_RST;
            errMsgReq         <= 1'b0;
            errMsgFatal       <= 1'b0;
            headerLogLoad     <= 1'b0;
        end else if (anyReset) begin
            fepValid          <= 1'b0;
            firstErrorPointer <= PCUEER_FEP_RST;
            errMsgReq         <= 1'b0;
            errMsgFatal       <= 1'b0;
            headerLogLoad     <= 1'b0;
        end else begin
            fepValid          <= next_fepValid;
            firstErrorPointer <= next_firstErrorPointer;
            errMsgReq         <= next_errMsgReq;
            errMsgFatal       <= next_errMsgFatal;
            headerLogLoad     <= next_headerLogLoad;
        end
    end

    // ==========================================================
    // registers: read answer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgReadData  <= 32'h0000_0000;
            cfgReadValid <= 1'b0;
        end else if (anyReset) begin
            cfgReadData  <= 32'h0000_0000;
            cfgReadValid <= 1'b0;
        end else begin
            cfgReadData  <= next_cfgReadData;
            cfgReadValid <= next_cfgReadValid;
        end
    end

endmodule : pcueer_regs

// ### inc/pcueer_pkg.sv
package pcueer_pkg;

    // ==========================================================
    // register offsets (byte addresses in extended config space)
    localparam logic [11:0] PCUEER_OFS_NEXT_CAP_VERSION = 12'h102;
    localparam logic [11:0] PCUEER_OFS_STATUS           = 12'h104;
    localparam logic [11:0] PCUEER_OFS_MASK             = 12'h108;
    localparam logic [11:0] PCUEER_OFS_SEVERITY         = 12'h10c;

    // ==========================================================
    // field positions
    localparam int PCUEER_BIT_UR      = 20;
    localparam int PCUEER_BIT_ECRC    = 19;
    localparam int PCUEER_BIT_MALF    = 18;
    localparam int PCUEER_BIT_OVRN    = 17;
    localparam int PCUEER_BIT_UNXP    = 16;
    localparam int PCUEER_BIT_CABT    = 15;
    localparam int PCUEER_BIT_CTMO    = 14;
    localparam int PCUEER_BIT_FCPE    = 13;
    localparam int PCUEER_BIT_PSN     = 12;
    localparam int PCUEER_BIT_DLLP    = 4;
    localparam int PCUEER_BIT_VC_EN   = 12;

    // ==========================================================
    // implemented bits and reset values
    localparam logic [31:0] PCUEER_IMPL_MASK    = 32'h001f_f010;
    localparam logic [31:0] PCUEER_STATUS_RST   = 32'h0000_0000;
    localparam logic [31:0] PCUEER_MASK_RST     = 32'h0000_0000;
    localparam logic [31:0] PCUEER_SEVERITY_RST = 32'h0006_2011;
    localparam logic [31:0] PCUEER_SEV_RO_ONE   = 32'h0000_0001;
    localparam logic [11:0] PCUEER_NEXT_PTR_VC  = 12'h150;
    localparam logic [11:0] PCUEER_NEXT_PTR_END = 12'h000;
    localparam logic [3:0]  PCUEER_CAP_REV      = 4'h1;
    localparam logic [4:0]  PCUEER_FEP_RST      = 5'h00;

endpackage : pcueer_pkg

// ### test/pcueer_checker.sv
`timescale 1ns/1ns
module pcueer_checker
    import pcueer_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        fundamentalReset,
    input wire logic        global_reset_input,
    input wire logic        powerOnReset,
    input wire logic        virtual_channel_capability_enable,
    input wire logic        cfgRead,
    input wire logic [11:0] cfgAddr,
    input wire logic [31:0] cfgReadData,
    input wire logic        cfgReadValid,
    input wire logic        errMsgReq,
    input wire logic        headerLogLoad,
    input wire logic [4:0]  firstErrorPointer
);
    // ==========================================================
    // helpers
    logic syncRst;
    logic mapped;
    assign syncRst = fundamentalReset | global_reset_input | powerOnReset;
    assign mapped  = cfgAddr inside {PCUEER_OFS_STATUS, PCUEER_OFS_MASK, PCUEER_OFS_SEVERITY};
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // assertions
    a_read_pulse: assert property (cfgRead && !syncRst |=> cfgReadValid)
        else $error("read not answered");
    a_idle_zero: assert property (!cfgRead |=> !cfgReadValid && cfgReadData == 32'h0000_0000)
        else $error("read bus not idle");
    a_version_word: assert property (cfgRead && !syncRst
        && cfgAddr == PCUEER_OFS_NEXT_CAP_VERSION |=>
        cfgReadData == {16'h0000, ($past(virtual_channel_capability_enable) ? PCUEER_NEXT_PTR_VC
        : PCUEER_NEXT_PTR_END), PCUEER_CAP_REV}) else $error("bad version word");
    a_unmapped_zero: assert property (cfgRead && !mapped && cfgAddr != PCUEER_OFS_NEXT_CAP_VERSION
        |=> cfgReadData == 32'h0000_0000) else $error("unmapped read not zero");
    a_reserved_zero: assert property (cfgRead && mapped |=>
        (cfgReadData & ~(PCUEER_IMPL_MASK | PCUEER_SEV_RO_ONE)) == 32'h0000_0000)
        else $error("reserved bits set");
    a_log_with_req: assert property (errMsgReq == headerLogLoad) else $error("log strobe apart");
    a_ptr_holds: assert property ($changed(firstErrorPointer) |-> errMsgReq || $past(syncRst))
        else $error("pointer moved alone");
    a_sync_reset: assert property (syncRst |=> !errMsgReq && firstErrorPointer == 5'h00)
        else $error("sync reset ignored");
    c_msg: cover property (errMsgReq);
    c_read: cover property (cfgReadValid);
    c_sync: cover property (syncRst);
endmodule : pcueer_checker

bind pcueer_regs pcueer_checker u_chk (.*);

// ### test/pcueer_host_model.sv
`timescale 1ns/1ns
module pcueer_host_model (
    input  wire logic        clk,
    output logic             cfgRead,
    output logic             cfgWrite,
    output logic      [11:0] cfgAddr,
    output logic      [3:0]  cfgByteEn,
    output logic      [31:0] cfgWriteData,
    input  wire logic [31:0] cfgReadData,
    input  wire logic        cfgReadValid
);
    initial {cfgRead, cfgWrite, cfgAddr, cfgByteEn, cfgWriteData} = '0;
    // ==========================================================
    // requests start just after an edge, are taken at the next one;
    // an idle cycle follows so back-to-back calls never retoggle a strobe
    // status clearing is done only by writing ones or by a reset
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        {cfgWrite, cfgAddr, cfgWriteData, cfgByteEn} = {1'b1, a, d, be};
        @(posedge clk);
        #1 cfgWrite = 1'b0;
        cfgWriteData = ~d;
        @(posedge clk);
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        {cfgRead, cfgAddr} = {1'b1, a};
        @(posedge clk);
        #1 cfgRead = 1'b0;
        // answer stands in this cycle; no valid strobe gives unknown data
        d = cfgReadValid ? cfgReadData : 32'hxxxx_xxxx;
        @(posedge clk);
        #1;
    endtask : rd
endmodule : pcueer_host_model

// ### test/pcueer_regs_tb_top.sv
`timescale 1ns/1ns
module pcueer_regs_tb_top;
    import pcueer_pkg::*;
    logic clk = 0, sys_rst = 1, vcEn = 0, rdv, req, fat, hll;
    logic [2:0] rs = '0;
    logic [9:0] flg = '0;
    logic rd_, wr_;
    logic [11:0] ad;
    logic [3:0] be;
    logic [31:0] wd, rdat, d;
    logic [4:0] fep;
    int n_mismatch = 0, total_checks = 0;
    int bp [10] = '{20, 19, 18, 17, 16, 15, 14, 13, 12, 4};
    always #25 clk = ~clk;
    pcueer_host_model host (.clk(clk), .cfgRead(rd_), .cfgWrite(wr_), .cfgAddr(ad),
        .cfgByteEn(be), .cfgWriteData(wd), .cfgReadData(rdat), .cfgReadValid(rdv));
    pcueer_regs DUT (.clk(clk), .sys_rst(sys_rst), .fundamentalReset(rs[0]),
        .global_reset_input(rs[1]), .powerOnReset(rs[2]),
        .virtual_channel_capability_enable(vcEn), .cfgRead(rd_), .cfgWrite(wr_),
        .cfgAddr(ad), .cfgByteEn(be), .cfgWriteData(wd),
        .unsupported_request_flag(flg[0]), .end_to_end_crc_flag(flg[1]),
        .malformed_packet_flag(flg[2]), .receiveCreditOverrunFlag(flg[3]),
        .unmatched_completion_flag(flg[4]), .completer_abort_flag(flg[5]),
        .completion_timer_expired_flag(flg[6]), .flow_credit_protocol_flag(flg[7]),
        .poisoned_packet_flag(flg[8]), .linkLayerProtocolFlag(flg[9]),
        .cfgReadData(rdat), .cfgReadValid(rdv), .errMsgReq(req), .errMsgFatal(fat),
        .firstErrorPointer(fep), .headerLogLoad(hll));
    // ==========================================================
    // checking
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic pulse(input logic [9:0] f);
        flg = f;
        @(posedge clk);
        #1 flg = '0;
    endtask : pulse
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    // watchdog: the sequence needs under two hundred cycles
    initial begin
        #(50 * 5000);
        n_mismatch++;
        final_report();
    end
    // ==========================================================
    // tests
    initial begin
        repeat (3) @(posedge clk);
        #1 sys_rst = 0;
        host.rd(PCUEER_OFS_NEXT_CAP_VERSION, d); chk(d, 32'h0000_0001);
        vcEn = 1;
        host.wr(PCUEER_OFS_NEXT_CAP_VERSION, '1, 4'hf);
        host.rd(PCUEER_OFS_NEXT_CAP_VERSION, d); chk(d, 32'h0000_1501);
        host.rd(PCUEER_OFS_MASK, d); chk(d, PCUEER_MASK_RST);
        host.rd(PCUEER_OFS_SEVERITY, d); chk(d, PCUEER_SEVERITY_RST);
        for (int i = 0; i < 10; i++) begin
            pulse(10'h001 << i);
            chk({hll, req, fat}, {2'b11, PCUEER_SEVERITY_RST[bp[i]]});
            chk(fep, bp[i]);
            host.rd(PCUEER_OFS_STATUS, d); chk(d, 32'h1 << bp[i]);
            host.wr(PCUEER_OFS_STATUS, '0, 4'hf);
            host.rd(PCUEER_OFS_STATUS, d); chk(d, 32'h1 << bp[i]);
            host.wr(PCUEER_OFS_STATUS, 32'h1 << bp[i], 4'hf);
            host.rd(PCUEER_OFS_STATUS, d); chk(d, 32'h0000_0000);
        end
        pulse(10'h104); chk({req, fat, fep}, {2'b11, 5'h0c});
        host.wr(PCUEER_OFS_STATUS, '1, 4'hf);
        host.rd(PCUEER_OFS_STATUS, d); chk(d, 32'h0000_0000);
        host.wr(PCUEER_OFS_MASK, '1, 4'hf);
        host.rd(PCUEER_OFS_MASK, d); chk(d, PCUEER_IMPL_MASK);
        pulse('1); chk(req, 1'b0);
        host.rd(PCUEER_OFS_STATUS, d); chk(d, 32'h0000_0000);
        host.wr(PCUEER_OFS_MASK, '0, 4'h4);
        host.rd(PCUEER_OFS_MASK, d); chk(d, 32'h0000_f010);
        host.wr(PCUEER_OFS_MASK, '0, 4'hf);
        host.wr(PCUEER_OFS_SEVERITY, '0, 4'hf);
        host.rd(PCUEER_OFS_SEVERITY, d); chk(d, 32'h0000_0001);
        pulse(10'h004); chk({req, fat}, 2'b10);
        host.wr(PCUEER_OFS_SEVERITY, '1, 4'hf);
        host.rd(PCUEER_OFS_SEVERITY, d); chk(d, 32'h001f_f011);
        host.wr(12'h110, '1, 4'hf);
        host.rd(12'h110, d); chk(d, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            pulse(10'h001);
            host.wr(PCUEER_OFS_SEVERITY, '0, 4'hf);
            host.wr(PCUEER_OFS_MASK, '1, 4'hf);
            rs[k] = 1'b1;
            @(posedge clk);
            #1 rs = '0;
            host.rd(PCUEER_OFS_MASK, d); chk(d, PCUEER_MASK_RST);
            host.rd(PCUEER_OFS_SEVERITY, d); chk(d, PCUEER_SEVERITY_RST);
            host.rd(PCUEER_OFS_STATUS, d); chk(d, PCUEER_STATUS_RST);
            chk(fep, PCUEER_FEP_RST);
        end
        final_report();
    end
endmodule : pcueer_regs_tb_top
